// *** logic/uafc_codec.sv ***
/*
 * Serial API frame codec. Deframes host bytes into messages for the packet
 * logic and frames device messages (transmit status, received packet, module
 * status) back to the host. Assumes an external UART supplies and takes
 * bytes with valid/ready; message bytes from packet logic start with the type.
 */
`timescale 1ns/10ps
`default_nettype none
module uafc_codec
    import uafc_pkg::*;
#(
    parameter int FIFO_DEPTH = UAFC_FIFO_DEPTH
) (
    // clock and reset
    input  wire logic       clk,
    input  wire logic       rstn,
    // configuration
    input  wire logic [1:0] framing_mode_select,
    // bytes from host uart
    input  wire logic       ser_rx_valid,
    output logic            ser_rx_ready,
    input  wire logic [7:0] ser_rx_data,
    // bytes to host uart
    output logic            ser_tx_valid,
    input  wire logic       ser_tx_ready,
    output logic [7:0]      ser_tx_data,
    // deframed messages to packet logic (type byte first)
    output logic            msg_out_valid,
    input  wire logic       msg_out_ready,
    output uafc_beat_t      msg_out,
    output logic            msg_drop,
    // messages from packet logic to frame for the host
    input  wire logic       msg_in_valid,
    output logic            msg_in_ready,
    input  wire uafc_beat_t msg_in,
    input  wire logic [15:0] msg_in_len
);
    // reset release
    logic [1:0] rst_sync;
    logic       rst_n;
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            rst_sync <= 2'h0;
        end else begin
            rst_sync <= {rst_sync[0], 1'b1};
        end
    end
    assign rst_n = rst_sync[1];

    typedef struct packed {
        uafc_rx_state_t rx;
        logic           rx_esc;
        logic [15:0]    rx_len;
        logic [7:0]     rx_sum;
        uafc_beat_t     rx_beat;
        logic           rx_beat_v;
        logic           drop;
        uafc_tx_state_t tx;
        logic [15:0]    tx_len;
        logic [7:0]     tx_sum;
        logic [7:0]     tx_byte;
        logic           tx_pend_esc;
        logic           tx_last;
        logic           tx_wait;
    } uafc_st_t;

    uafc_st_t st;
    uafc_st_t next_st;

    logic       fifo_in_ready;
    logic       api_on;
    logic       esc_on;
    logic       rx_take;
    logic [7:0] rx_byte;
    logic       rx_is_data;
    logic       tx_take;
    logic [7:0] tx_raw;
    logic       tx_need_esc;
    logic       tx_transp;

    assign api_on = (framing_mode_select == UAFC_MODE_API) || esc_on;
    assign esc_on = (framing_mode_select == UAFC_MODE_ESC);

    // receive side stalls while a decoded byte waits on the fifo
    assign ser_rx_ready = !st.rx_beat_v || fifo_in_ready;
    assign rx_take      = ser_rx_valid && ser_rx_ready;
    assign rx_byte      = st.rx_esc ? (ser_rx_data ^ UAFC_ESC_XOR) : ser_rx_data;

    // transmit side: escape stuffing and checksum over raw values
    assign ser_tx_valid = (st.tx != UAFC_TX_IDLE) && !st.tx_wait;
    assign ser_tx_data  = st.tx_pend_esc ? UAFC_ESC : st.tx_byte;
    assign tx_take      = ser_tx_valid && ser_tx_ready;
    assign msg_in_ready = !api_on ? (st.tx == UAFC_TX_IDLE) || tx_take
                                  : (st.tx == UAFC_TX_LEN_LO || st.tx == UAFC_TX_DATA)
                                    && (tx_take || st.tx_wait) && !st.tx_pend_esc && !st.tx_last
                                    && (st.tx == UAFC_TX_DATA || msg_in_len != UAFC_LEN_ZERO);
    assign tx_transp    = !api_on && msg_in_valid && msg_in_ready;
    assign tx_raw       = msg_in.data;

    function automatic logic reserved(input logic [7:0] b);
        reserved = (b == UAFC_DELIM) || (b == UAFC_ESC)
                   || (b == UAFC_XON) || (b == UAFC_XOFF);
    endfunction : reserved

    assign tx_need_esc = esc_on && reserved(tx_raw);

    always_comb begin
        next_st    = st;
        rx_is_data = 1'b0;
        next_st.drop = 1'b0;
        if (st.rx_beat_v && fifo_in_ready) begin
            next_st.rx_beat_v = 1'b0;
        end
        // ---------------- receive / deframe ----------------
        if (rx_take) begin
            if (!api_on) begin
                next_st.rx_beat.data = ser_rx_data;
                next_st.rx_beat.last = 1'b1;
                next_st.rx_beat_v    = 1'b1;
            end else if (ser_rx_data == UAFC_DELIM && (esc_on || st.rx == UAFC_RX_HUNT)) begin
                next_st.drop   = (st.rx != UAFC_RX_HUNT);
                next_st.rx     = UAFC_RX_LEN_HI;
                next_st.rx_esc = 1'b0;
            end else if (esc_on && ser_rx_data == UAFC_ESC && !st.rx_esc
                         && st.rx != UAFC_RX_HUNT) begin
                next_st.rx_esc = 1'b1;
            end else begin
                next_st.rx_esc = 1'b0;
                case (st.rx)
                    UAFC_RX_HUNT: begin
                        next_st.rx = UAFC_RX_HUNT;
                    end
                    UAFC_RX_LEN_HI: begin
                        next_st.rx_len = {rx_byte, UAFC_ZERO};
                        next_st.rx     = UAFC_RX_LEN_LO;
                    end
                    UAFC_RX_LEN_LO: begin
                        next_st.rx_len = {st.rx_len[15:8], rx_byte};
                        next_st.rx_sum = UAFC_ZERO;
                        if ({st.rx_len[15:8], rx_byte} == UAFC_LEN_ZERO) begin
                            next_st.rx = UAFC_RX_HUNT;
                        end else begin
                            next_st.rx = UAFC_RX_DATA;
                        end
                    end
                    UAFC_RX_DATA: begin
                        rx_is_data           = 1'b1;
                        next_st.rx_sum       = st.rx_sum + rx_byte;
                        next_st.rx_len       = st.rx_len - UAFC_LEN_ONE;
                        next_st.rx_beat.data = rx_byte;
                        next_st.rx_beat.last = 1'b0;
                        next_st.rx_beat_v    = 1'b1;
                        if (st.rx_len == UAFC_LEN_ONE) begin
                            next_st.rx = UAFC_RX_CSUM;
                        end
                    end
                    UAFC_RX_CSUM: begin
                        next_st.rx = UAFC_RX_HUNT;
                        if (8'(st.rx_sum + rx_byte) == UAFC_CSUM_GOOD) begin
                            next_st.rx_beat.data = UAFC_ZERO;
                            next_st.rx_beat.last = 1'b1;
                            next_st.rx_beat_v    = 1'b1;
                        end else begin
                            next_st.drop = 1'b1;
                        end
                    end
                    default: begin
                        next_st.rx = UAFC_RX_HUNT;
                    end
                endcase
            end
        end
        // ---------------- transmit / frame ----------------
        case (st.tx)
            UAFC_TX_IDLE: begin
                if (api_on && msg_in_valid) begin
                    next_st.tx      = UAFC_TX_DELIM;
                    next_st.tx_byte = UAFC_DELIM;
                    next_st.tx_len  = msg_in_len;
                    next_st.tx_sum  = UAFC_ZERO;
                    next_st.tx_last = 1'b0;
                end
            end
            UAFC_TX_DELIM: begin
                if (tx_take) begin
                    next_st.tx_byte     = st.tx_len[15:8];
                    next_st.tx_pend_esc = esc_on && reserved(st.tx_len[15:8]);
                    next_st.tx          = UAFC_TX_LEN_HI;
                end
            end
            UAFC_TX_LEN_HI, UAFC_TX_LEN_LO, UAFC_TX_DATA: begin
                if (tx_take && st.tx_pend_esc) begin
                    next_st.tx_pend_esc = 1'b0;
                    next_st.tx_byte     = st.tx_byte ^ UAFC_ESC_XOR;
                end else if (tx_take && st.tx == UAFC_TX_LEN_HI) begin
                    next_st.tx_byte     = st.tx_len[7:0];
                    next_st.tx_pend_esc = esc_on && reserved(st.tx_len[7:0]);
                    next_st.tx          = UAFC_TX_LEN_LO;
                end else if (tx_take && (st.tx_last || st.tx_len == UAFC_LEN_ZERO)) begin
                    next_st.tx_byte     = UAFC_CSUM_GOOD - st.tx_sum;
                    next_st.tx_pend_esc = esc_on && reserved(UAFC_CSUM_GOOD - st.tx_sum);
                    next_st.tx          = UAFC_TX_CSUM;
                end else if ((tx_take || st.tx_wait) && msg_in_valid) begin
                    next_st.tx_byte     = tx_raw;
                    next_st.tx_pend_esc = tx_need_esc;
                    next_st.tx_sum      = st.tx_sum + tx_raw;
                    next_st.tx_len      = st.tx_len - UAFC_LEN_ONE;
                    next_st.tx_last     = (st.tx_len == UAFC_LEN_ONE) || msg_in.last;
                    next_st.tx          = UAFC_TX_DATA;
                    next_st.tx_wait     = 1'b0;
                end else if (tx_take) begin
                    // byte gone but next one not offered: keep it from going out twice
                    next_st.tx_wait     = 1'b1;
                end
            end
            UAFC_TX_CSUM: begin
                if (tx_take && st.tx_pend_esc) begin
                    next_st.tx_pend_esc = 1'b0;
                    next_st.tx_byte     = st.tx_byte ^ UAFC_ESC_XOR;
                end else if (tx_take) begin
                    next_st.tx = UAFC_TX_IDLE;
                end
            end
            default: begin
                next_st.tx = UAFC_TX_IDLE;
            end
        endcase
        // framing off: bytes go out one at a time unframed; a frame in flight is cut
        if (!api_on) begin
            if (tx_transp) begin
                next_st.tx      = UAFC_TX_DATA;
                next_st.tx_byte = msg_in.data;
            end else if (!ser_tx_valid || tx_take) begin
                next_st.tx      = UAFC_TX_IDLE;
            end
            next_st.tx_pend_esc = 1'b0;
            next_st.tx_wait     = 1'b0;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    uafc_fifo #(
        .WIDTH ($bits(uafc_beat_t)),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .clk       (clk),
        .rst_n     (rst_n),
        .in_valid  (st.rx_beat_v),
        .in_ready  (fifo_in_ready),
        .in_data   (st.rx_beat),
        .out_valid (msg_out_valid),
        .out_ready (msg_out_ready),
        .out_data  (msg_out)
    );

    assign msg_drop = st.drop;

    AST_HUNT_NO_OUTPUT: assert property (@(posedge clk) disable iff (!rst_n)
        (api_on && st.rx == UAFC_RX_HUNT && rx_take && ser_rx_data != UAFC_DELIM)
        |=> !st.rx_beat_v || $past(st.rx_beat_v))
        else $error("byte outside frame reached packet logic");
    AST_DELIM_STARTS: assert property (@(posedge clk) disable iff (!rst_n)
        (api_on && st.rx == UAFC_RX_HUNT && rx_take && ser_rx_data == UAFC_DELIM)
        |=> st.rx == UAFC_RX_LEN_HI)
        else $error("delimiter did not start a frame");
    AST_ESC_RESTART: assert property (@(posedge clk) disable iff (!rst_n)
        (esc_on && rx_take && ser_rx_data == UAFC_DELIM && st.rx == UAFC_RX_DATA)
        |=> st.rx == UAFC_RX_LEN_HI && st.drop)
        else $error("raw delimiter did not restart frame");
    AST_ESC_FOLLOW: assert property (@(posedge clk) disable iff (!rst_n)
        (tx_take && st.tx_pend_esc && st.tx != UAFC_TX_IDLE)
        |=> ser_tx_data == ($past(st.tx_byte) ^ UAFC_ESC_XOR))
        else $error("escaped byte not xored");
    AST_NO_RAW_RESERVED: assert property (@(posedge clk) disable iff (!rst_n)
        (esc_on && ser_tx_valid && st.tx != UAFC_TX_DELIM)
        |-> !(ser_tx_data == UAFC_DELIM || ser_tx_data == UAFC_XON
              || ser_tx_data == UAFC_XOFF))
        else $error("reserved byte sent unescaped");
    AST_DELIM_FIRST: assert property (@(posedge clk) disable iff (!rst_n)
        (st.tx == UAFC_TX_IDLE && api_on && msg_in_valid)
        |=> ser_tx_valid && ser_tx_data == UAFC_DELIM)
        else $error("frame did not begin with delimiter");
    AST_CSUM_OK: assert property (@(posedge clk) disable iff (!rst_n)
        (st.tx == UAFC_TX_CSUM && !st.tx_pend_esc && ser_tx_valid)
        |-> 8'(st.tx_sum + ser_tx_data) == UAFC_CSUM_GOOD
            || (esc_on && reserved(ser_tx_data ^ UAFC_ESC_XOR)
                && 8'(st.tx_sum + (ser_tx_data ^ UAFC_ESC_XOR)) == UAFC_CSUM_GOOD))
        else $error("sent checksum wrong");
    AST_BAD_CSUM_DROP: assert property (@(posedge clk) disable iff (!rst_n)
        (api_on && rx_take && st.rx == UAFC_RX_CSUM && !st.rx_esc
         && ser_rx_data != UAFC_DELIM && ser_rx_data != UAFC_ESC
         && 8'(st.rx_sum + ser_rx_data) != UAFC_CSUM_GOOD)
        |=> st.drop)
        else $error("bad checksum not dropped");
    AST_TRANSP_PASS: assert property (@(posedge clk) disable iff (!rst_n)
        (!api_on && msg_in_valid && msg_in_ready)
        |=> ser_tx_valid && ser_tx_data == $past(msg_in.data))
        else $error("transparent byte not passed on");
    AST_DATA_BEAT: assert property (@(posedge clk) disable iff (!rst_n)
        rx_is_data |=> st.rx_beat_v && !st.rx_beat.last)
        else $error("frame data byte not passed on");

    COV_GOOD_FRAME:  cover property (@(posedge clk) disable iff (!rst_n)
        st.rx == UAFC_RX_CSUM && rx_take ##1 st.rx_beat_v && st.rx_beat.last);
    COV_TX_FRAME:    cover property (@(posedge clk) disable iff (!rst_n)
        st.tx == UAFC_TX_CSUM && tx_take && !st.tx_pend_esc);
    COV_ESC_RX:      cover property (@(posedge clk) disable iff (!rst_n)
        esc_on && st.rx_esc && rx_take);
    COV_FIFO_FULL:   cover property (@(posedge clk) disable iff (!rst_n)
        st.rx_beat_v && !fifo_in_ready);

endmodule : uafc_codec
`default_nettype wire

// *** common/uafc_pkg.sv ***
/*
 * Package for the serial API frame codec: framing constants, mode and message
 * type encodings, and the carrier structs shared by the codec and its FIFO.
 * Assumes byte streams on the serial side come from an external UART.
 */
// How it works
// - frame is 0x7e, two length bytes, frame data, one checksum byte
// - length is big-endian, counts unescaped frame data only
// - escaped mode escapes reserved bytes in both directions
// - escape emits 0x7d then byte xor 0x20; receiver undoes it
// - reserved bytes are 0x7e, 0x7d, 0x11 and 0x13
// - checksum runs over unescaped values only
// - sender checksum is 0xff minus eight-bit sum of frame data
// - receiver accepts only when data plus checksum sums to 0xff
// - first frame data byte is the message type
// - multi-byte payload fields go most significant byte first
// - device sends module status frames 0x8a unprompted on events
// - device answers each transmit request with status frame 0x89
// - received radio packets go to host in frames of type 0x80
// - bytes before delimiter are dropped; bad frames lose their end beat and pulse msg_drop
// - mode 0 transparent, 1 unescaped frames, 2 escaped frames
package uafc_pkg;
    localparam logic [7:0] UAFC_DELIM     = 8'h7e;
    localparam logic [7:0] UAFC_ESC       = 8'h7d;
    localparam logic [7:0] UAFC_XON       = 8'h11;
    localparam logic [7:0] UAFC_XOFF      = 8'h13;
    localparam logic [7:0] UAFC_ESC_XOR   = 8'h20;
    localparam logic [7:0] UAFC_CSUM_GOOD = 8'hff;
    localparam logic [7:0] UAFC_ZERO      = 8'h00;
    localparam logic [15:0] UAFC_LEN_ZERO = 16'h0000;
    localparam logic [15:0] UAFC_LEN_ONE  = 16'h0001;

    localparam logic [7:0] UAFC_TYPE_TX_REQ    = 8'h00;
    localparam logic [7:0] UAFC_TYPE_RX_PKT    = 8'h80;
    localparam logic [7:0] UAFC_TYPE_TX_STATUS = 8'h89;
    localparam logic [7:0] UAFC_TYPE_MOD_STAT  = 8'h8a;

    localparam logic [1:0] UAFC_MODE_TRANSP = 2'h0;
    localparam logic [1:0] UAFC_MODE_API    = 2'h1;
    localparam logic [1:0] UAFC_MODE_ESC    = 2'h2;

    localparam int UAFC_FIFO_DEPTH = 4;

    // byte with end-of-message mark, used on the message streams to and from packet logic
    typedef struct packed {
        logic [7:0] data;
        logic       last;
    } uafc_beat_t;

    typedef enum logic [2:0] {
        UAFC_RX_HUNT, UAFC_RX_LEN_HI, UAFC_RX_LEN_LO, UAFC_RX_DATA, UAFC_RX_CSUM
    } uafc_rx_state_t;

    typedef enum logic [2:0] {
        UAFC_TX_IDLE, UAFC_TX_DELIM, UAFC_TX_LEN_HI, UAFC_TX_LEN_LO,
        UAFC_TX_DATA, UAFC_TX_CSUM
    } uafc_tx_state_t;
endpackage : uafc_pkg

// *** logic/uafc_fifo.sv ***
/*
 * Small synchronous FIFO holding up to DEPTH received beats on their way to
 * the packet logic. Assumes both sides run on the codec clock and reset.
 */
`timescale 1ns/10ps
`default_nettype none
module uafc_fifo
    import uafc_pkg::*;
#(
    parameter int WIDTH = 9,
    parameter int DEPTH = UAFC_FIFO_DEPTH
) (
    // clock and reset
    input  wire logic             clk,
    input  wire logic             rst_n,
    // fill side
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    // drain side
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic [WIDTH-1:0]      out_data
);
    localparam int AW = $clog2(DEPTH);

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [AW-1:0]               wr;
        logic [AW-1:0]               rd;
        logic [AW:0]                 count;
    } uafc_fifo_st_t;

    uafc_fifo_st_t st;
    uafc_fifo_st_t next_st;
    logic          push;
    logic          pop;

    assign in_ready  = (st.count != (AW+1)'(DEPTH));
    assign out_valid = (st.count != '0);
    assign out_data  = st.mem[st.rd];
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;

    always_comb begin
        next_st = st;
        if (push) begin
            next_st.mem[st.wr] = in_data;
            next_st.wr = (st.wr == AW'(DEPTH-1)) ? '0 : st.wr + 1'b1;
        end
        if (pop) begin
            next_st.rd = (st.rd == AW'(DEPTH-1)) ? '0 : st.rd + 1'b1;
        end
        next_st.count = st.count + (AW+1)'(push) - (AW+1)'(pop);
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    AST_FIFO_NO_OVERFLOW: assert property (@(posedge clk) disable iff (!rst_n)
        st.count <= (AW+1)'(DEPTH))
        else $error("fifo count beyond depth");
endmodule : uafc_fifo
`default_nettype wire

// *** dv/uafc_host_model.sv ***
/*
 * Host side of the codec's serial byte streams: sends byte lists and
 * collects framed bytes from the device, stalling when asked.
 * Assumes the testbench calls send_bytes and reads got.
 */
`timescale 1ns/10ps
`default_nettype none
module uafc_host_model
    import uafc_pkg::*;
(
    // clock
    input  wire logic       clk,
    // bytes to device
    output logic            ser_rx_valid,
    input  wire logic       ser_rx_ready,
    output logic [7:0]      ser_rx_data,
    // bytes from device
    input  wire logic       ser_tx_valid,
    output logic            ser_tx_ready,
    input  wire logic [7:0] ser_tx_data,
    // pacing
    input  wire logic       stall
);
    logic [7:0] got[$];
    logic [3:0] pace;
    initial begin
        ser_rx_valid = 1'b0;
        ser_rx_data  = 8'h00;
        ser_tx_ready = 1'b0;
        pace         = 4'h0;
    end
    // a byte is held until the edge that takes it; released line shows inverse
    task automatic send_bytes(input logic [7:0] q[$]);
        int n;
        foreach (q[i]) begin
            @(negedge clk);
            ser_rx_valid <= 1'b1;
            ser_rx_data  <= q[i];
            n = 0;
            do begin
                @(posedge clk);
                n++;
            end while (ser_rx_ready !== 1'b1 && n < 300);
        end
        @(negedge clk);
        ser_rx_valid <= 1'b0;
        ser_rx_data  <= ~q[q.size()-1];
    endtask : send_bytes
    always @(negedge clk) begin
        pace         <= pace + 4'h1;
        ser_tx_ready <= !(stall && pace[1]);
    end
    always @(posedge clk) begin
        if (ser_tx_valid && ser_tx_ready) got.push_back(ser_tx_data);
    end
endmodule : uafc_host_model
`default_nettype wire

// *** dv/uafc_codec_test.sv ***
/*
 * Self-checking bench for the frame codec: deframing in both framed modes,
 * drops, restart, transparent mode, framing of device messages, FIFO full.
 * Assumes the host model sits on the serial streams.
 */
`timescale 1ns/10ps
`default_nettype none
module uafc_codec_test;
    import uafc_pkg::*;
    logic clk = 1'b0, rstn = 1'b0, out_rdy = 1'b0, stall = 1'b0, in_valid = 1'b0;
    logic [1:0] mode = UAFC_MODE_API;
    logic [15:0] in_len = UAFC_LEN_ZERO;
    uafc_beat_t in_beat = '0, msg_out;
    logic rx_v, rx_r, tx_v, tx_r, out_v, drop, in_rdy;
    logic [7:0] rx_d, tx_d;
    logic [8:0] beats[$];
    int errors = 0, check_count = 0, drops = 0;
    always #2.5 clk = ~clk;
    uafc_codec #(.FIFO_DEPTH(4)) dut_u (.clk(clk), .rstn(rstn), .framing_mode_select(mode),
        .ser_rx_valid(rx_v), .ser_rx_ready(rx_r), .ser_rx_data(rx_d), .ser_tx_valid(tx_v),
        .ser_tx_ready(tx_r), .ser_tx_data(tx_d), .msg_out_valid(out_v), .msg_out_ready(out_rdy),
        .msg_out(msg_out), .msg_drop(drop), .msg_in_valid(in_valid), .msg_in_ready(in_rdy),
        .msg_in(in_beat), .msg_in_len(in_len));
    uafc_host_model host_u (.clk(clk), .ser_rx_valid(rx_v), .ser_rx_ready(rx_r),
        .ser_rx_data(rx_d), .ser_tx_valid(tx_v), .ser_tx_ready(tx_r), .ser_tx_data(tx_d),
        .stall(stall));
    always @(posedge clk) begin
        if (out_v && out_rdy) beats.push_back(msg_out);
        if (drop === 1'b1) drops++;
    end
    task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
        check_count++;
        if (seen !== exp) begin
            errors++;
            $display("mismatch %s expected %h seen %h", name, exp, seen);
        end
    endtask : check
    // waits for exp.size() beats, then compares and clears the list
    task automatic check_beats(input logic [8:0] exp[$], input int n_drop);
        int n;
        n = 0;
        while (beats.size() < exp.size() && n < 400) begin
            @(posedge clk);
            n++;
        end
        repeat (20) @(posedge clk);
        check("beat count", beats.size(), exp.size());
        foreach (exp[i]) if (i < beats.size()) check("beat", beats[i], exp[i]);
        check("drops", drops, n_drop);
        beats = {};
        drops = 0;
    endtask : check_beats
    task automatic set_mode(input logic [1:0] m);
        @(negedge clk);
        mode <= m;
        repeat (2) @(negedge clk);
    endtask : set_mode
    function automatic logic [8:0] bt(input logic [7:0] d, input logic l);
        return {d, l};
    endfunction : bt
    task automatic t_rx_plain();
        set_mode(UAFC_MODE_API);
        host_u.send_bytes('{8'h55, 8'h11, 8'h7e, 8'h00, 8'h02, 8'h23, 8'h11, 8'hcb});
        check_beats('{bt(8'h23, 0), bt(8'h11, 0), bt(8'h00, 1)}, 0);
        host_u.send_bytes('{8'h7e, 8'h00, 8'h03, 8'h00, 8'h41, 8'h42, 8'h7c});
        check_beats('{bt(8'h00, 0), bt(8'h41, 0), bt(8'h42, 0), bt(8'h00, 1)}, 0);
        host_u.send_bytes('{8'h7e, 8'h00, 8'h02, 8'h23, 8'h11, 8'hcc});
        check_beats('{bt(8'h23, 0), bt(8'h11, 0)}, 1);
        host_u.send_bytes('{8'h7e, 8'h00, 8'h00, 8'hff});
        repeat (20) @(posedge clk);
        check("zero length beats", beats.size(), 0);
        check("zero length drops", drops, 0);
        drops = 0;
    endtask : t_rx_plain
    task automatic t_rx_esc();
        set_mode(UAFC_MODE_ESC);
        host_u.send_bytes('{8'h7e, 8'h00, 8'h02, 8'h23, 8'h7d, 8'h31, 8'hcb});
        check_beats('{bt(8'h23, 0), bt(8'h11, 0), bt(8'h00, 1)}, 0);
        host_u.send_bytes('{8'h7e, 8'h00, 8'h05, 8'h23, 8'h7e, 8'h00, 8'h02, 8'h23, 8'h7d,
                            8'h31, 8'hcb});
        check_beats('{bt(8'h23, 0), bt(8'h23, 0), bt(8'h11, 0), bt(8'h00, 1)}, 1);
    endtask : t_rx_esc
    task automatic t_transp();
        set_mode(UAFC_MODE_TRANSP);
        host_u.send_bytes('{8'h7e, 8'h41});
        check_beats('{bt(8'h7e, 1), bt(8'h41, 1)}, 0);
    endtask : t_transp
    task automatic t_fifo_full();
        set_mode(UAFC_MODE_API);
        out_rdy <= 1'b0;
        fork
            host_u.send_bytes('{8'h7e, 8'h00, 8'h06, 8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h06,
                                8'hea});
            begin
                repeat (40) @(posedge clk);
                check("ready while full", rx_r, 0);
                @(negedge clk);
                out_rdy <= 1'b1;
            end
        join
        check_beats('{bt(8'h01, 0), bt(8'h02, 0), bt(8'h03, 0), bt(8'h04, 0), bt(8'h05, 0),
                      bt(8'h06, 0), bt(8'h00, 1)}, 0);
    endtask : t_fifo_full
    // frames one device message and compares the bytes sent to the host
    task automatic t_tx(input logic [1:0] m, input logic [7:0] q[$], input logic [7:0] exp[$]);
        int n;
        set_mode(m);
        host_u.got = {};
        stall <= 1'b1;
        in_len <= q.size();
        foreach (q[i]) begin
            @(negedge clk);
            in_valid <= 1'b1;
            in_beat <= {q[i], i == q.size() - 1};
            n = 0;
            do begin
                @(posedge clk);
                n++;
            end while (in_rdy !== 1'b1 && n < 300);
        end
        @(negedge clk);
        in_valid <= 1'b0;
        n = 0;
        while (host_u.got.size() < exp.size() && n < 400) begin
            @(posedge clk);
            n++;
        end
        repeat (10) @(posedge clk);
        check("tx count", host_u.got.size(), exp.size());
        foreach (exp[i]) if (i < host_u.got.size()) check("tx byte", host_u.got[i], exp[i]);
        stall <= 1'b0;
    endtask : t_tx
    task automatic results();
        $display("comparisons %0d mismatches %0d", check_count, errors);
        if (errors == 0 && check_count > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : results
    initial begin
        #(60000 * 5);
        errors++;
        results();
    end
    initial begin
        repeat (16) @(negedge clk);
        rstn <= 1'b1;
        repeat (4) @(negedge clk);
        out_rdy <= 1'b1;
        t_rx_plain();
        t_rx_esc();
        t_transp();
        t_fifo_full();
        t_tx(UAFC_MODE_ESC, '{8'h23, 8'h11}, '{8'h7e, 8'h00, 8'h02, 8'h23, 8'h7d, 8'h31,
             8'hcb});
        t_tx(UAFC_MODE_API, '{8'h89, 8'h01, 8'h00}, '{8'h7e, 8'h00, 8'h03, 8'h89, 8'h01, 8'h00,
             8'h75});
        t_tx(UAFC_MODE_ESC, '{8'h80, 8'h7e, 8'h13}, '{8'h7e, 8'h00, 8'h03, 8'h80, 8'h7d, 8'h5e,
             8'h7d, 8'h33, 8'hee});
        t_tx(UAFC_MODE_API, '{8'h8a, 8'h02}, '{8'h7e, 8'h00, 8'h02, 8'h8a, 8'h02, 8'h73});
        t_tx(UAFC_MODE_TRANSP, '{8'h7e, 8'h41}, '{8'h7e, 8'h41});
        results();
    end
endmodule : uafc_codec_test
`default_nettype wire
